// file: shared/tcs_pkg.sv
/*
 * constants, state codes and timing counts shared by the temperature
 * conversion sequencer and its helpers.
 * assumes a 20 MHz reference clock; counts are derived from that rate.
 */
package tcs_pkg;

    // reference clock rate
    localparam int CLK_PERIOD_NS = 50;

    // conversion schedule, times as printed
    localparam int UPDATE_RATE_US = 400;
    localparam int CONV_TIME_US = 25;

    // cycles per update period, a nominal figure so plain division
    localparam int UPDATE_CYC = (UPDATE_RATE_US * 1000) / CLK_PERIOD_NS;
    // conversion length, least time so rounded up
    localparam int CONV_CYC =
        (CONV_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // width of the schedule counters
    localparam int TICK_W = 16;

    // result register layout
    localparam int RESULT_W = 10;
    localparam logic [9:0] RESULT_RESET = 10'h000;
    localparam logic [9:0] TEMP_MAX_CODE = 10'h1FC;
    localparam logic [9:0] TEMP_MIN_CODE = 10'h200;

    // serial frame layout, edges counted from zero
    localparam int CNT_W = 5;
    localparam logic [4:0] FRAME_EDGES = 5'h10;
    localparam logic [4:0] LEAD_ZERO_EDGE = 5'h00;
    localparam logic [4:0] LAST_DATA_EDGE = 5'h0A;
    localparam logic [4:0] CTRL_LOAD_EDGE = 5'h0E;
    localparam logic [4:0] PD_FALL_EDGE = 5'h02;

    // identification strap level presented to the master
    localparam logic STRAP_LEVEL = 1'b0;

    // sequencer states
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_SHUTDOWN = 2'b10
    } tcs_state_t;

endpackage

// file: hw/tcs_sync.sv
/*
 * two flip-flop level synchroniser, one lane per bit.
 * assumes each input lane is a level that stays put for several
 * destination clock cycles; words must not pass through it.
 */
`timescale 1ns/1ns

module tcs_sync
#(
    parameter int WIDTH = 2
)
(
    // destination clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    ////////////////////////////////////////////////////////////////////
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta <= async_i;
            sync_o <= meta;
        end
    end

endmodule

// file: hw/tcs_temp_conversion_sequencer.sv
/*
 * conversion sequencer and serial result port of a 10-bit temperature
 * sensor: schedules conversions from the reference clock, holds the
 * result and serves it over a four-wire slave port.
 * assumes the analog front end presents a settled twos-complement code
 * on temp_code_i by the end of each conversion, and that the master
 * keeps the select low between accesses so the serial clock rests.
 */
`timescale 1ns/1ns

// Notes on behaviour
// - select high enables port; clock ignored otherwise
// - serial output shifts out the result register
// - serial input shifts toward the control register
// - conversions use internal clock, never serial clock
// - normal mode converts every 400 us
// - conversion lasts 25 us, then idle
// - latest completed result always readable
// - shutdown stops oscillator and further conversions
// - shutdown keeps and returns the last result
// - end of any transfer outside shutdown restarts a conversion
// - leaving shutdown restarts a conversion
// - read during conversion returns previous data
// - result is read-only 10-bit twos complement
// - codes span minus 128 to plus 127
// - quarter degree per step, zero is zero
// - 16 clocks, leading zero, 10 bits, hold
// - input sampled falling, output changed rising
// - third control bit requests shutdown, others ignored
// - control loads on 15th rise, else unchanged
module tcs_temp_conversion_sequencer
    import tcs_pkg::*;
#(
    parameter int UPDATE_CYCLES = UPDATE_CYC,
    parameter int CONV_CYCLES = CONV_CYC
)
(
    // reference clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // serial link from the master
    input wire logic sclk_i,
    input wire logic ce_i,
    input wire logic control_in_line_i,
    output logic result_out_line_o,
    output logic result_out_line_oe_o,
    output logic identify_strap_o,
    // analog front end
    input wire logic [RESULT_W-1:0] temp_code_i,
    output logic converting_o,
    // status
    output logic shutdown_o,
    output logic [RESULT_W-1:0] temp_reading_o
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    // keep the code inside the printable range of the format
    function automatic logic [RESULT_W-1:0] clamp_code
    (
        input logic [RESULT_W-1:0] code
    );
        return (!code[RESULT_W-1] && code > TEMP_MAX_CODE) ?
            TEMP_MAX_CODE : code;
    endfunction

    // bit of the held result sent on a given rising edge
    function automatic logic frame_bit
    (
        input logic [RESULT_W-1:0] word,
        input logic [CNT_W-1:0] edge_idx
    );
        logic [CNT_W-1:0] pos;
        pos = LAST_DATA_EDGE - edge_idx;
        return word[pos[3:0]];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // link side declarations
    logic [CNT_W-1:0] rise_cnt;
    logic [CNT_W-1:0] fall_cnt;
    logic pd_sample;
    logic wr_toggle;
    logic wr_pd;
    logic out_bit;

    // reference side
    logic ce_s;
    logic tog_s;
    logic ce_d;
    logic tog_d;
    logic transfer_end;
    logic ctrl_load;
    logic go_down;
    logic wake_up;
    logic shutdown;
    logic [RESULT_W-1:0] result;
    logic [RESULT_W-1:0] held_word;
    tcs_state_t state;
    tcs_state_t next_state;
    logic [TICK_W-1:0] tick_cnt;
    logic [TICK_W-1:0] conv_cnt;
    logic conv_start;
    logic conv_done;

    ////////////////////////////////////////////////////////////////////
    // link domain, clocked by the master's serial clock

    // rising edges of this frame; select low holds it cleared, so
    // edges outside a frame are ignored
    always_ff @(posedge sclk_i or negedge ce_i)
    begin
        if (!ce_i)
        begin
            rise_cnt <= '0;
        end
        else if (rise_cnt != FRAME_EDGES)
        begin
            rise_cnt <= rise_cnt + 5'h01;
        end
    end

    // output changes on rising edges only: leading zero, ten result
    // bits msb first, then the last bit stays until select falls
    always_ff @(posedge sclk_i or negedge ce_i)
    begin
        if (!ce_i)
        begin
            out_bit <= 1'b0;
        end
        else if (rise_cnt == LEAD_ZERO_EDGE)
        begin
            out_bit <= 1'b0;
        end
        else if (rise_cnt <= LAST_DATA_EDGE)
        begin
            out_bit <= frame_bit(held_word, rise_cnt);
        end
    end

    // falling edges sample the input; only the third bit matters,
    // the first two and the rest are don't care to this logic
    always_ff @(negedge sclk_i or negedge ce_i)
    begin
        if (!ce_i)
        begin
            fall_cnt <= '0;
            pd_sample <= 1'b0;
        end
        else
        begin
            if (fall_cnt != FRAME_EDGES)
            begin
                fall_cnt <= fall_cnt + 5'h01;
            end
            if (fall_cnt == PD_FALL_EDGE)
            begin
                pd_sample <= control_in_line_i;
            end
        end
    end

    // 15th rising edge loads the control word; a frame cut short
    // never reaches it, so nothing changes. the toggle tells the
    // reference side, and the value waits stable beside it
    always_ff @(posedge sclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_toggle <= 1'b0;
            wr_pd <= 1'b0;
        end
        else if (ce_i && rise_cnt == CTRL_LOAD_EDGE)
        begin
            wr_toggle <= ~wr_toggle;
            wr_pd <= pd_sample;
        end
    end

    // drive the line only while selected, released as select falls
    assign result_out_line_oe_o = ce_i;
    assign result_out_line_o = out_bit;

    ////////////////////////////////////////////////////////////////////
    // crossing into the reference domain

    tcs_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i({ce_i, wr_toggle}),
        .sync_o({ce_s, tog_s})
    );

    // delayed copies for edge detection on the synchronised levels
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            ce_d <= 1'b0;
            tog_d <= 1'b0;
        end
        else
        begin
            ce_d <= ce_s;
            tog_d <= tog_s;
        end
    end

    // a transfer ends when select falls, read or write alike
    assign transfer_end = ce_d & ~ce_s;
    assign ctrl_load = tog_s ^ tog_d;
    assign go_down = ctrl_load & wr_pd;
    assign wake_up = ctrl_load & ~wr_pd & shutdown;

    ////////////////////////////////////////////////////////////////////
    // control register

    // shutdown flag; reset leaves the part in normal mode
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            shutdown <= 1'b0;
        end
        else if (ctrl_load)
        begin
            shutdown <= wr_pd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // conversion sequencer, on the internal clock only

    // next state; shutdown beats any restart in the same cycle
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (go_down)
                begin
                    next_state = ST_SHUTDOWN;
                end
                else if (transfer_end ||
                    tick_cnt == TICK_W'(UPDATE_CYCLES - 1))
                begin
                    next_state = ST_CONVERT;
                end
            end
            ST_CONVERT:
            begin
                if (go_down)
                begin
                    next_state = ST_SHUTDOWN;
                end
                else if (conv_done && !transfer_end)
                begin
                    next_state = ST_IDLE;
                end
            end
            ST_SHUTDOWN:
            begin
                if (wake_up)
                begin
                    next_state = ST_CONVERT;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // a start is entry into convert, or a restart while converting
    assign conv_done = (conv_cnt == TICK_W'(CONV_CYCLES - 1));
    assign conv_start = (next_state == ST_CONVERT) &&
        (state != ST_CONVERT || transfer_end);

    // state register
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // update period counter runs from each conversion start, so a
    // restart also shifts the 400 us schedule
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || conv_start || next_state == ST_SHUTDOWN)
        begin
            tick_cnt <= '0;
        end
        else
        begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end

    // conversion length counter
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || conv_start)
        begin
            conv_cnt <= '0;
        end
        else if (state == ST_CONVERT)
        begin
            conv_cnt <= conv_cnt + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // result register

    // only a completed conversion writes it; an aborted one or a
    // shutdown leaves the previous code in place
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            result <= RESULT_RESET;
        end
        else if (state == ST_CONVERT && next_state == ST_IDLE)
        begin
            result <= clamp_code(temp_code_i);
        end
    end

    // copy seen by the serial side; frozen while selected so a frame
    // never mixes two results. limitation: the master must allow one
    // reference clock period and then one more after select rises before the first bit
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            held_word <= RESULT_RESET;
        end
        else if (!ce_s)
        begin
            held_word <= result;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign identify_strap_o = STRAP_LEVEL; // a fixed tie, never changes
    assign converting_o = (state == ST_CONVERT);
    assign shutdown_o = shutdown;
    assign temp_reading_o = result;

endmodule

// file: dv/tcs_seq_checker.sv
/* port assertions for the temperature conversion sequencer.
   assumes select stays low during reset and frames are whole. */
`timescale 1ns/1ns
module tcs_seq_checker
    import tcs_pkg::*;
#(
    parameter int UPDATE_CYCLES = UPDATE_CYC,
    parameter int CONV_CYCLES = CONV_CYC
)
(
    // clock, reset and select
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // watched outputs and the code they carry
    input wire logic result_out_line_oe_o,
    input wire logic [RESULT_W-1:0] temp_code_i,
    input wire logic converting_o,
    input wire logic shutdown_o,
    input wire logic [RESULT_W-1:0] temp_reading_o
);
    default clocking ck @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);
    int since_start;
    int ce_low;
    // top step clamp, kept apart from the design's own
    function automatic logic [9:0] clamp(input logic [9:0] c);
        return (!c[9] && c > TEMP_MAX_CODE) ? TEMP_MAX_CODE : c;
    endfunction
    ////////////////////////////////////////
    // idle cycles since the last conversion or shutdown
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || converting_o || shutdown_o)
            since_start <= 0;
        else
            since_start <= since_start + 1;
    end
    // cycles with select low, saturating so it cannot wrap
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i || ce_i)
            ce_low <= 0;
        else if (ce_low < 15)
            ce_low <= ce_low + 1;
    end
    ////////////////////////////////////////
    oe_follows_ce_a: assert property (
        result_out_line_oe_o == ce_i) else $error("enable not select");
    period_bound_a: assert property (
        since_start <= UPDATE_CYCLES + 2) else $error("conversion overdue");
    conv_length_a: assert property (
        $fell(converting_o) && !shutdown_o
        |-> $past(converting_o, CONV_CYCLES)) else $error("short conversion");
    shut_idle_a: assert property (
        shutdown_o ##1 shutdown_o |-> !converting_o)
        else $error("conversion in shutdown");
    shut_keep_a: assert property (
        shutdown_o ##1 shutdown_o |-> $stable(temp_reading_o))
        else $error("result moved in shutdown");
    result_at_end_a: assert property (
        !$stable(temp_reading_o) |-> $fell(converting_o))
        else $error("result moved mid conversion");
    result_code_a: assert property (
        $fell(converting_o) && !shutdown_o
        |-> temp_reading_o == clamp($past(temp_code_i)))
        else $error("wrong result code");
    xfer_restart_a: assert property (
        $fell(ce_i) |-> ##[1:6] (converting_o || shutdown_o))
        else $error("no restart after transfer");
    wake_restart_a: assert property (
        $fell(shutdown_o) |-> ##[0:2] converting_o)
        else $error("no restart after wake");
    ctrl_quiet_a: assert property (
        $changed(shutdown_o) |-> ce_low < 6)
        else $error("control changed without frame");
endmodule

bind tcs_temp_conversion_sequencer tcs_seq_checker #(
    .UPDATE_CYCLES(UPDATE_CYCLES),
    .CONV_CYCLES(CONV_CYCLES)
) tcs_seq_checker_inst (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .result_out_line_oe_o(result_out_line_oe_o),
    .temp_code_i(temp_code_i),
    .converting_o(converting_o),
    .shutdown_o(shutdown_o),
    .temp_reading_o(temp_reading_o)
);

// file: dv/tcs_master.sv
/* serial master model for the sequencer's four-wire port.
   assumes one caller of xfer at a time. */
`timescale 1ns/1ns
module tcs_master
(
    // link lines
    output logic sclk_o,
    output logic ce_o,
    output logic ctrl_bit_o,
    input wire logic result_bit_i
);
    localparam int HALF_NS = 24;
    // link clock rests low outside frames
    initial
    begin
        sclk_o = 1'b0;
        // deferred, so the port sees a first fall and clears its counters
        ce_o <= 1'b0;
        ctrl_bit_o = 1'b0;
    end
    // n pulses: drive after each rise, sample at each fall
    task automatic xfer(input logic [15:0] wr, input int n,
        output logic [15:0] rd);
        rd = 16'h0000;
        #13 ce_o = 1'b1;
        #200;
        for (int k = 0; k < n; k++)
        begin
            sclk_o = 1'b1;
            #1 ctrl_bit_o = wr[15-k];
            #(HALF_NS-1) sclk_o = 1'b0;
            rd[15-k] = result_bit_i;
            #HALF_NS;
        end
        ce_o = 1'b0;
        ctrl_bit_o = ~ctrl_bit_o; // held value lapses
    endtask
endmodule

// file: dv/tb_temp_conversion_sequencer.sv
/* self-checking bench for the temperature conversion sequencer.
   assumes the master model owns the link lines. */
`timescale 1ns/1ns
module tb_temp_conversion_sequencer
    import tcs_pkg::*;
();
    localparam int UPD = 200;
    localparam int CONV = 20;
    logic ref_clk_i = 1'b0;
    logic rst_i;
    logic [9:0] temp_code_i = 10'h000;
    logic sclk, ce, ctl_line, res_bit, res_oe, strap, conv, shdn;
    logic [9:0] reading;
    logic [15:0] rd;
    int errors = 0;
    int num_checks = 0;
    logic [9:0] corner [7] = '{10'h200, 10'h3FF, 10'h000, 10'h001,
        10'h1FC, 10'h1FD, 10'h1FF};
    // released line shows the inverse, never a stale level
    wire res_line = res_oe ? res_bit : ~res_bit;
    // reference clock
    initial
    begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    tcs_temp_conversion_sequencer #(
        .UPDATE_CYCLES(UPD),
        .CONV_CYCLES(CONV)
    ) tcs_temp_conversion_sequencer_inst (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .sclk_i(sclk),
        .ce_i(ce),
        .control_in_line_i(ctl_line),
        .result_out_line_o(res_bit),
        .result_out_line_oe_o(res_oe),
        .identify_strap_o(strap),
        .temp_code_i(temp_code_i),
        .converting_o(conv),
        .shutdown_o(shdn),
        .temp_reading_o(reading)
    );
    tcs_master tcs_master_inst (
        .sclk_o(sclk),
        .ce_o(ce),
        .ctrl_bit_o(ctl_line),
        .result_bit_i(res_line)
    );
    ////////////////////////////////////////
    // helpers: waits, compares and expectations
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    function automatic logic [9:0] expect_code(input logic [9:0] c);
        return (c[9] == 1'b0 && c > 10'h1FC) ? TEMP_MAX_CODE : c;
    endfunction
    function automatic logic [15:0] word_of(input logic [9:0] v);
        return {1'b0, v, {5{v[0]}}};
    endfunction
    task automatic set_code(input logic [9:0] c);
        @(posedge ref_clk_i);
        temp_code_i <= c;
        #1;
    endtask
    task automatic wait_conv(input logic lvl, output int t);
        t = 0;
        while (conv !== lvl && t < UPD + 10)
        begin
            tick(1);
            t++;
        end
    endtask
    task automatic conv_done(output int len, output int gap);
        wait_conv(1'b1, gap);
        wait_conv(1'b0, len);
    endtask
    task automatic frame(input logic [15:0] wr, input int n);
        tcs_master_inst.xfer(wr, n, rd);
        tick(1);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    // main sequence
    initial
    begin
        int len;
        int gap;
        logic [9:0] c;
        logic [9:0] old;
        // a real rising edge, so the link write toggle clears too
        rst_i <= 1'b1;
        void'($urandom(95638));
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        tick(2);
        chk("reading", 16'(RESULT_RESET), 16'(reading));
        chk("shutdown", 16'h0000, 16'(shdn));
        chk("strap", 16'(STRAP_LEVEL), 16'(strap));
        c = 10'($urandom);
        set_code(c);
        conv_done(len, gap);
        chk("length", 16'(CONV), 16'(len));
        conv_done(len, gap);
        chk("idle gap", 16'(UPD - CONV), 16'(gap));
        chk("reading", 16'(expect_code(c)), 16'(reading));
        for (int i = 0; i < 12; i++)
        begin
            c = (i < 7) ? corner[i] : 10'($urandom);
            set_code(c);
            conv_done(len, gap);
            if (i > 0)
                chk("restart", 16'h0001, 16'(gap < 8));
            chk("code", 16'(expect_code(c)), 16'(reading));
            frame({2'($urandom), 14'h0000}, 16);
            chk("word", word_of(expect_code(c)), rd);
        end
        // a read launched inside a conversion
        old = reading;
        c = ~old;
        set_code(c);
        wait_conv(1'b1, gap);
        frame(16'h0000, 16);
        chk("word", word_of(old), rd);
        conv_done(len, gap);
        chk("reading", 16'(expect_code(c)), 16'(reading));
        // shutdown, a short frame, then wake
        frame({2'($urandom), 14'h2000}, 16);
        tick(8);
        chk("shutdown", 16'h0001, 16'(shdn));
        old = reading;
        c = ~old;
        set_code(c);
        tick(UPD + CONV);
        chk("held", 16'(old), 16'(reading));
        frame(16'h0000, 14);
        tick(8);
        chk("shutdown", 16'h0001, 16'(shdn));
        chk("release", 16'h0000, 16'(res_oe));
        chk("word", word_of(old) & 16'hFFFC, rd);
        frame(16'h0000, 16);
        conv_done(len, gap);
        chk("shutdown", 16'h0000, 16'(shdn));
        chk("wake", 16'h0001, 16'(gap < 8));
        chk("reading", 16'(expect_code(c)), 16'(reading));
        end_of_test();
    end
    // watchdog well beyond the expected run
    initial
    begin
        tick(40 * UPD);
        errors++;
        end_of_test();
    end
endmodule
